// File: hw/smio_pkg.sv
// smio_pkg: constants and types shared by the static memory / io bus block
// assumes: single 10 MHz clock domain, no software-visible registers
package smio_pkg;
  localparam int SMIO_DATA_W = 16;
  localparam int SMIO_ADDR_W = 24;
  localparam int SMIO_IO_WIN_BYTES = 16384;
  localparam int SMIO_IO_WIN_W = 14;
  localparam int SMIO_CLK_HZ = 10000000;
  // default access strobe width, in cycles of mclk
  localparam logic [3:0] SMIO_ACC_CYC_RST = 4'h3;
  // bank decode codes held in the target field of a request
  localparam logic [2:0] SMIO_TGT_MEM0 = 3'h0;
  localparam logic [2:0] SMIO_TGT_MEM1 = 3'h1;
  localparam logic [2:0] SMIO_TGT_IO0 = 3'h2;
  localparam logic [2:0] SMIO_TGT_IO1 = 3'h3;
  localparam logic [2:0] SMIO_TGT_IO2 = 3'h4;
  localparam logic [2:0] SMIO_TGT_NAND = 3'h5;
  // nand cycle kinds
  localparam logic [1:0] SMIO_NAND_DATA = 2'h0;
  localparam logic [1:0] SMIO_NAND_CMD = 2'h1;
  localparam logic [1:0] SMIO_NAND_ADDR = 2'h2;
  typedef enum logic [1:0] {
    SMIO_IDLE = 2'b00,
    SMIO_SETUP = 2'b01,
    SMIO_STROBE = 2'b11,
    SMIO_HOLD = 2'b10
  } smio_state_t;
endpackage

// File: hw/smio_sync_if.sv
// smio_sync_if: carries a raw pin into the synchroniser and its clean level out
// assumes: both ends run on mclk
`timescale 1ns/100ps
`default_nettype none
interface smio_sync_if;
  logic raw;
  logic clean;
  modport core (output raw, input clean);
  modport sync (input raw, output clean);
endinterface
`default_nettype wire

// File: hw/smio_pin_sync.sv
// smio_pin_sync: three-stage synchroniser for an asynchronous pin input
// assumes: mclk domain, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module smio_pin_sync
  import smio_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  smio_sync_if.sync sif
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic clean_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end else begin
      s1_ff <= sif.raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clean_ff <= RST_VAL;
    end else if (s2_ff == s3_ff) begin
      clean_ff <= s3_ff;
    end
  end

  assign sif.clean = clean_ff;
endmodule
`default_nettype wire

// File: hw/smio_bus.sv
// smio_bus: static memory, external io and nand strobe engine on a shared data bus
// assumes: requests come from on-chip logic on mclk; ext_wait_n is an asynchronous pin
`timescale 1ns/100ps
`default_nettype none
module smio_bus
  import smio_pkg::*;
#(
  parameter int DATA_W = SMIO_DATA_W,
  parameter int ADDR_W = SMIO_ADDR_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [2:0] req_target,
  input wire logic [1:0] req_nand_kind,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [1:0] req_byte_en,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic bus_8bit,
  input wire logic boot_from_mem0,
  input wire logic mem_bank_swap,
  input wire logic [3:0] access_cycles,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic req_error,
  output logic [ADDR_W-1:0] ext_addr,
  input wire logic [DATA_W-1:0] ext_data_bus_in,
  output logic [DATA_W-1:0] ext_data_bus_out,
  output logic ext_data_bus_oe_n,
  output logic mem_bank0_select_n,
  output logic mem_bank1_select_n,
  output logic io_bank0_select_n,
  output logic io_bank1_select_n,
  output logic io_bank2_select_n,
  output logic ext_output_enable_n,
  output logic write_byte_enable_hi_n,
  output logic write_byte_enable_lo_n,
  output logic nand_cmd_latch_en,
  output logic nand_addr_latch_en,
  output logic nand_bank1_enable_n,
  input wire logic ext_wait_n
);
  // lane steering and the io window decode are written for these sizes only
  if (DATA_W != 16 || ADDR_W <= SMIO_IO_WIN_W) begin : g_width_check
    $error("smio_bus: unsupported width");
  end

  smio_state_t state_ff;
  logic [3:0] cnt_ff;
  logic wr_ff;
  logic [2:0] tgt_ff;
  logic bus8_ff;
  logic [1:0] be_ff;
  logic err_ff;
  logic rsp_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [5:0] sel_n_ff;
  logic oe_n_ff;
  logic we_hi_n_ff;
  logic we_lo_n_ff;
  logic cle_ff;
  logic ale_ff;
  logic drive_ff;
  logic wait_clean;
  logic [2:0] phys_tgt;
  logic bad_req;
  logic [3:0] strobe_len;

  smio_sync_if wsif ();
  assign wsif.raw = ext_wait_n;
  assign wait_clean = wsif.clean;

  smio_pin_sync #(
    .RST_VAL(1'b1)
  ) u_wait_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sif(wsif)
  );

  // maps a logical memory bank onto a physical select
  function automatic logic [2:0] map_target(input logic [2:0] tgt, input logic swap,
                                            input logic boot0);
    logic [2:0] t;
    t = tgt;
    if ((tgt == SMIO_TGT_MEM0 || tgt == SMIO_TGT_MEM1) && swap && !boot0) begin
      t = (tgt == SMIO_TGT_MEM0) ? SMIO_TGT_MEM1 : SMIO_TGT_MEM0;
    end
    return t;
  endfunction

  // one-hot active-low select pattern, at most one bit low
  function automatic logic [5:0] sel_pattern(input logic [2:0] tgt);
    logic [5:0] s;
    s = 6'h3f;
    if (tgt <= SMIO_TGT_NAND) begin
      s[tgt] = 1'b0;
    end
    return s;
  endfunction

  // a request is taken only in idle and only when it decodes to a real bank
  function automatic logic take_ok(input smio_state_t st, input logic valid, input logic bad);
    return (st == SMIO_IDLE) && valid && !bad;
  endfunction

  // the strobe ends on its last counted cycle once the synchronised wait pin is high;
  // nand cycles never look at wait
  function automatic logic strobe_done(input smio_state_t st, input logic [3:0] cnt,
                                       input logic wait_hi, input logic [2:0] tgt);
    return (st == SMIO_STROBE) && (cnt <= 4'h1) && (wait_hi || tgt == SMIO_TGT_NAND);
  endfunction

  // boot strap pins mem0 onto the low bank regardless of swap
  assign phys_tgt = map_target(req_target, mem_bank_swap, boot_from_mem0);
  // io windows are 16 KB; addresses beyond are refused
  assign bad_req = (req_target > SMIO_TGT_NAND) ||
                   ((req_target >= SMIO_TGT_IO0) && (req_target <= SMIO_TGT_IO2) &&
                    (req_addr[ADDR_W-1:SMIO_IO_WIN_W] != '0));
  assign strobe_len = (access_cycles == 4'h0) ? 4'h1 : access_cycles;

  // only one access owns the bus, so requests wait in idle
  assign req_ready = (state_ff == SMIO_IDLE);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= SMIO_IDLE;
    end else begin
      unique case (state_ff)
        SMIO_IDLE: begin
          if (take_ok(state_ff, req_valid, bad_req)) begin
            state_ff <= SMIO_SETUP;
          end
        end
        SMIO_SETUP: begin
          state_ff <= SMIO_STROBE;
        end
        SMIO_STROBE: begin
          // the wait pin arrives some four cycles late: shorter strobes cannot be
          // stretched, and a device must pull it low early in a long one
          if (strobe_done(state_ff, cnt_ff, wait_clean, tgt_ff)) begin
            state_ff <= SMIO_HOLD;
          end
        end
        SMIO_HOLD: begin
          state_ff <= SMIO_IDLE;
        end
      endcase
    end
  end

  // strobe length counter, loaded on the way into the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_ff <= 4'h0;
    end else if (state_ff == SMIO_SETUP) begin
      cnt_ff <= strobe_len;
    end else if (state_ff == SMIO_STROBE && cnt_ff > 4'h1) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_ff <= 1'b0;
      tgt_ff <= SMIO_TGT_MEM0;
      bus8_ff <= 1'b0;
      be_ff <= 2'h0;
      addr_ff <= '0;
      wdata_ff <= '0;
    end else if (state_ff == SMIO_IDLE && req_valid && !bad_req) begin
      wr_ff <= req_write;
      tgt_ff <= phys_tgt;
      // width is latched so a change mid-access cannot split a read
      bus8_ff <= bus_8bit;
      // narrow bus moves one byte on the low lane
      be_ff <= bus_8bit ? 2'h1 : req_byte_en;
      addr_ff <= req_addr;
      wdata_ff <= bus_8bit ? {8'h00, (req_byte_en[1] ? req_wdata[15:8] : req_wdata[7:0])}
                           : req_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sel_n_ff <= 6'h3f;
    end else if (state_ff == SMIO_IDLE && req_valid && !bad_req) begin
      sel_n_ff <= sel_pattern(phys_tgt);
    end else if (state_ff == SMIO_HOLD) begin
      sel_n_ff <= 6'h3f;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      oe_n_ff <= 1'b1;
    end else if (state_ff == SMIO_SETUP) begin
      oe_n_ff <= wr_ff;
    end else if (strobe_done(state_ff, cnt_ff, wait_clean, tgt_ff)) begin
      oe_n_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      we_hi_n_ff <= 1'b1;
      we_lo_n_ff <= 1'b1;
    end else if (state_ff == SMIO_SETUP) begin
      we_hi_n_ff <= !(wr_ff && be_ff[1] && tgt_ff != SMIO_TGT_NAND);
      we_lo_n_ff <= !(wr_ff && (be_ff[0] || tgt_ff == SMIO_TGT_NAND));
    end else if (strobe_done(state_ff, cnt_ff, wait_clean, tgt_ff)) begin
      we_hi_n_ff <= 1'b1;
      we_lo_n_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cle_ff <= 1'b0;
      ale_ff <= 1'b0;
    end else if (take_ok(state_ff, req_valid, bad_req) && phys_tgt == SMIO_TGT_NAND) begin
      cle_ff <= (req_nand_kind == SMIO_NAND_CMD);
      ale_ff <= (req_nand_kind == SMIO_NAND_ADDR);
    end else if (state_ff == SMIO_HOLD) begin
      cle_ff <= 1'b0;
      ale_ff <= 1'b0;
    end
  end

  // bus driven from setup through hold on writes so data outlasts the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      drive_ff <= 1'b0;
    end else if (state_ff == SMIO_IDLE && req_valid && !bad_req) begin
      drive_ff <= req_write;
    end else if (state_ff == SMIO_HOLD) begin
      drive_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsp_ff <= 1'b0;
    end else begin
      rsp_ff <= (state_ff == SMIO_HOLD);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= (state_ff == SMIO_IDLE) && req_valid && bad_req;
    end
  end

  // read data holds until the next read so a slow consumer still finds it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else if (!wr_ff && strobe_done(state_ff, cnt_ff, wait_clean, tgt_ff)) begin
      rdata_ff <= bus8_ff ? {8'h00, ext_data_bus_in[7:0]} : ext_data_bus_in;
    end
  end

  assign ext_addr = addr_ff;
  assign ext_data_bus_out = wdata_ff;
  assign ext_data_bus_oe_n = !drive_ff;
  assign mem_bank0_select_n = sel_n_ff[SMIO_TGT_MEM0];
  assign mem_bank1_select_n = sel_n_ff[SMIO_TGT_MEM1];
  assign io_bank0_select_n = sel_n_ff[SMIO_TGT_IO0];
  assign io_bank1_select_n = sel_n_ff[SMIO_TGT_IO1];
  assign io_bank2_select_n = sel_n_ff[SMIO_TGT_IO2];
  assign nand_bank1_enable_n = sel_n_ff[SMIO_TGT_NAND];
  assign ext_output_enable_n = oe_n_ff;
  assign write_byte_enable_hi_n = we_hi_n_ff;
  assign write_byte_enable_lo_n = we_lo_n_ff;
  assign nand_cmd_latch_en = cle_ff;
  assign nand_addr_latch_en = ale_ff;
  assign rsp_valid = rsp_ff;
  assign rsp_rdata = rdata_ff;
  assign req_error = err_ff;
endmodule
`default_nettype wire

// File: bench/smio_checker.sv
// smio_checker: port-level properties of the shared static bus engine
// assumes: bound to smio_bus, one mclk domain, sync reset
`timescale 1ns/100ps
`default_nettype none
module smio_checker
  import smio_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [2:0] req_target,
  input wire logic [23:0] req_addr,
  input wire logic req_error,
  input wire logic mem_bank0_select_n,
  input wire logic mem_bank1_select_n,
  input wire logic io_bank0_select_n,
  input wire logic io_bank1_select_n,
  input wire logic io_bank2_select_n,
  input wire logic nand_bank1_enable_n,
  input wire logic ext_output_enable_n,
  input wire logic write_byte_enable_hi_n,
  input wire logic write_byte_enable_lo_n,
  input wire logic nand_cmd_latch_en,
  input wire logic nand_addr_latch_en,
  input wire logic ext_data_bus_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [5:0] sel;
  logic take;
  assign sel = ~{nand_bank1_enable_n, io_bank2_select_n, io_bank1_select_n,
    io_bank0_select_n, mem_bank1_select_n, mem_bank0_select_n};
  assign take = req_valid && req_ready;
  property p_one;
    $onehot0(sel);
  endproperty
  a_one: assert property (p_one) else $error("two selects low");
  property p_busy;
    take |=> !req_ready || req_error;
  endproperty
  a_busy: assert property (p_busy) else $error("second take while busy");
  property p_win;
    take && req_target == SMIO_TGT_IO2 && req_addr[14] |-> ##[1:2] req_error;
  endproperty
  a_win: assert property (p_win) else $error("io window overrun accepted");
  property p_oe;
    !ext_output_enable_n |-> ext_data_bus_oe_n && sel != 6'h0;
  endproperty
  a_oe: assert property (p_oe) else $error("read strobe bad");
  property p_hi;
    !write_byte_enable_hi_n |-> !ext_data_bus_oe_n && sel[5] == 1'b0;
  endproperty
  a_hi: assert property (p_hi) else $error("high write strobe bad");
  property p_lo;
    !write_byte_enable_lo_n |-> !ext_data_bus_oe_n && sel != 6'h0;
  endproperty
  a_lo: assert property (p_lo) else $error("low write strobe bad");
  property p_cle;
    nand_cmd_latch_en |-> sel == 6'h20 && !nand_addr_latch_en;
  endproperty
  a_cle: assert property (p_cle) else $error("command latch bad");
  property p_ale;
    nand_addr_latch_en |-> sel == 6'h20;
  endproperty
  a_ale: assert property (p_ale) else $error("address latch bad");
  c_rd: cover property (!ext_output_enable_n);
  c_ale: cover property (nand_addr_latch_en);
  c_err: cover property (req_error);
endmodule
`default_nettype wire

// File: bench/smio_mem_model.sv
// smio_mem_model: behavioural memory/io device on the shared bus
// assumes: strobes from smio_bus; stall sets wait length per strobe
`timescale 1ns/100ps
`default_nettype none
module smio_mem_model (
  input wire logic mclk,
  input wire logic mem_bank1_select_n,
  input wire logic ext_output_enable_n,
  input wire logic write_byte_enable_hi_n,
  input wire logic write_byte_enable_lo_n,
  input wire logic [23:0] ext_addr,
  input wire logic [15:0] ext_data_bus_out,
  input wire logic [3:0] stall,
  output logic [15:0] ext_data_bus_in,
  output logic ext_wait_n,
  output logic [15:0] last_wr
);
  logic [15:0] mem_ff [16];
  logic [15:0] held_ff = 16'h0;
  logic [3:0] wcnt_ff = 4'h0;
  logic act_ff = 1'b0;
  logic act;
  logic [3:0] idx;
  assign idx = {!mem_bank1_select_n, ext_addr[2:0]};
  assign act = !(ext_output_enable_n && write_byte_enable_lo_n && write_byte_enable_hi_n);
  // a released bus shows the inverse of the last word, never a stale copy
  assign ext_data_bus_in = ext_output_enable_n ? ~held_ff : mem_ff[idx];
  assign ext_wait_n = !(act && (!act_ff ? stall != 4'h0 : wcnt_ff != 4'h0));
  always_ff @(posedge mclk) begin
    act_ff <= act;
    if (act && !act_ff && stall != 4'h0) begin
      wcnt_ff <= stall - 4'h1;
    end else if (wcnt_ff != 4'h0) begin
      wcnt_ff <= wcnt_ff - 4'h1;
    end
    if (!ext_output_enable_n) held_ff <= mem_ff[idx];
    if (!write_byte_enable_lo_n) mem_ff[idx][7:0] <= ext_data_bus_out[7:0];
    if (!write_byte_enable_hi_n) mem_ff[idx][15:8] <= ext_data_bus_out[15:8];
    if (act && ext_output_enable_n) last_wr <= ext_data_bus_out;
  end
endmodule
`default_nettype wire

// File: bench/test_static_memory_io_bus.sv
// test_static_memory_io_bus: directed scenarios for smio_bus
// assumes: smio_mem_model on the far side, checker bound below
`timescale 1ns/100ps
`default_nettype none
module test_static_memory_io_bus
  import smio_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic bus_8bit = 1'b0;
  logic boot_from_mem0 = 1'b0;
  logic mem_bank_swap = 1'b0;
  logic [2:0] req_target = 3'h0;
  logic [1:0] req_nand_kind = 2'h0;
  logic [1:0] req_byte_en = 2'h3;
  logic [23:0] req_addr = 24'h0;
  logic [15:0] req_wdata = 16'h0;
  logic [3:0] access_cycles = 4'h2;
  logic [3:0] stall = 4'h0;
  wire req_ready, rsp_valid, req_error, ext_data_bus_oe_n, ext_wait_n, ext_output_enable_n;
  wire mem_bank0_select_n, mem_bank1_select_n, io_bank0_select_n, io_bank1_select_n;
  wire io_bank2_select_n, nand_bank1_enable_n, nand_cmd_latch_en, nand_addr_latch_en;
  wire write_byte_enable_hi_n, write_byte_enable_lo_n;
  wire [23:0] ext_addr;
  wire [15:0] rsp_rdata, ext_data_bus_in, ext_data_bus_out, last_wr;
  int n_errors = 0;
  int check_count = 0;
  int slen;
  logic [5:0] seen;
  logic [1:0] lat;
  logic got_err;
  smio_bus i_dut (.*);
  smio_mem_model i_mem (.*);
  initial forever #50 mclk = ~mclk;
  // sampled mid-cycle so the strobes seen are settled
  always @(negedge mclk) begin
    if (!(ext_output_enable_n && write_byte_enable_lo_n && write_byte_enable_hi_n)) slen++;
    seen |= ~{nand_bank1_enable_n, io_bank2_select_n, io_bank1_select_n, io_bank0_select_n,
      mem_bank1_select_n, mem_bank0_select_n};
    lat |= {nand_cmd_latch_en, nand_addr_latch_en};
  end
  task automatic close_out;
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic [2:0] t, input logic [1:0] k, input logic w,
      input logic [1:0] be, input logic [23:0] a, input logic [15:0] d);
    int i;
    @(posedge mclk);
    {req_target, req_nand_kind, req_write, req_byte_en} <= {t, k, w, be};
    req_addr <= a;
    req_wdata <= d;
    req_valid <= 1'b1;
    slen = 0;
    seen = 6'h0;
    lat = 2'h0;
    @(negedge mclk);
    for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge mclk);
    if (i == 50) begin
      n_errors++;
      close_out;
    end
    @(posedge mclk);
    req_valid <= 1'b0;
    for (i = 0; i < 60 && rsp_valid !== 1'b1 && req_error !== 1'b1; i++) @(negedge mclk);
    got_err = req_error;
    if (i == 60) begin
      n_errors++;
      close_out;
    end
  endtask
  task automatic sc_rw;
    acc(SMIO_TGT_MEM0, 2'h0, 1'b1, 2'h3, 24'h1, 16'ha5c3);
    chk("sel", 16'(seen), 16'h0001);
    chk("len", 16'(slen), 16'h0002);
    acc(SMIO_TGT_MEM0, 2'h0, 1'b1, 2'h2, 24'h1, 16'h0000);
    acc(SMIO_TGT_MEM0, 2'h0, 1'b0, 2'h3, 24'h1, 16'h0);
    chk("rd", rsp_rdata, 16'h00c3);
  endtask
  task automatic sc_map;
    @(posedge mclk);
    mem_bank_swap <= 1'b1;
    acc(SMIO_TGT_MEM0, 2'h0, 1'b1, 2'h3, 24'h2, 16'h5a5a);
    chk("swap", 16'(seen), 16'h0002);
    @(posedge mclk);
    boot_from_mem0 <= 1'b1;
    acc(SMIO_TGT_MEM0, 2'h0, 1'b0, 2'h3, 24'h1, 16'h0);
    chk("boot", 16'(seen), 16'h0001);
    @(posedge mclk);
    boot_from_mem0 <= 1'b0;
    mem_bank_swap <= 1'b0;
  endtask
  task automatic sc_io;
    for (int k = 0; k < 3; k++) begin
      acc(SMIO_TGT_IO0 + 3'(k), 2'h0, 1'b1, 2'h3, 24'h3fff, 16'h1234);
      chk("io", 16'(seen), 16'(6'h04 << k));
    end
    acc(SMIO_TGT_IO2, 2'h0, 1'b0, 2'h3, 24'h4000, 16'h0);
    chk("win", 16'(got_err), 16'h0001);
  endtask
  task automatic sc_wait;
    @(posedge mclk);
    access_cycles <= 4'h8;
    stall <= 4'h6;
    acc(SMIO_TGT_MEM0, 2'h0, 1'b0, 2'h3, 24'h1, 16'h0);
    chk("wait", 16'(slen > 8), 16'h0001);
    @(posedge mclk);
    stall <= 4'h0;
    access_cycles <= 4'h2;
  endtask
  task automatic sc_nand;
    @(posedge mclk);
    bus_8bit <= 1'b1;
    acc(SMIO_TGT_MEM0, 2'h0, 1'b1, 2'h2, 24'h3, 16'hbe12);
    chk("lane", 16'(last_wr[7:0]), 16'h00be);
    @(posedge mclk);
    bus_8bit <= 1'b0;
    acc(SMIO_TGT_NAND, SMIO_NAND_CMD, 1'b1, 2'h3, 24'h0, 16'h0070);
    chk("cmd", 16'({lat, seen}), 16'h00a0);
    acc(SMIO_TGT_NAND, SMIO_NAND_ADDR, 1'b1, 2'h3, 24'h0, 16'h0011);
    chk("adr", 16'({lat, seen}), 16'h0060);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    sc_rw;
    sc_map;
    sc_io;
    sc_wait;
    sc_nand;
    close_out;
  end
endmodule
bind smio_bus smio_checker i_chk (.*);
`default_nettype wire
